// [include/regmap_pkg.sv]
// Constants, types and carriers shared by the register-file address decoder
package regmap_pkg;

   // ********************************************************************
   // Bus widths and storage
   // ********************************************************************
   localparam int PM_AW = 16;
   localparam int RB_W = 8;
   localparam int PHYS_AW = 12;

   // ********************************************************************
   // Program memory map
   // ********************************************************************
   localparam logic [15:0] VECTOR_END = 16'h00ff;
   localparam logic [15:0] OPT_FIRST = 16'h003c;
   localparam logic [15:0] OPT_LAST = 16'h003f;
   localparam logic [15:0] OPT_HI_ADDR = 16'h003e;
   localparam logic [15:0] OPT_LO_ADDR = 16'h003f;
   localparam logic [15:0] RESET_PC = 16'h0100;
   localparam logic [15:0] OPT_RST = 16'h0000;

   // ********************************************************************
   // Register file map
   // ********************************************************************
   localparam logic [7:0] SET1_BASE = 8'hc0;
   localparam logic [7:0] COMMON_END = 8'hcf;
   localparam logic [7:0] BANKED_BASE = 8'he0;
   localparam logic [7:0] SLICE_LOW_ADDR = 8'hd6;
   localparam logic [7:0] SLICE_HIGH_ADDR = 8'hd7;
   localparam logic [7:0] PAGE_PTR_ADDR = 8'hdf;
   localparam logic [3:0] PAGE_COUNT = 4'h6;
   localparam logic [3:0] SET2_PAGES = 4'h4;

   // ********************************************************************
   // Values after reset
   // ********************************************************************
   localparam logic [7:0] PAGE_RST = 8'h00;
   localparam logic [7:0] SLICE_LOW_RST = 8'hc0;
   localparam logic [7:0] SLICE_HIGH_RST = 8'hc8;
   localparam logic BANK_RST = 1'b0;

   // ********************************************************************
   // APB register offsets
   // ********************************************************************
   localparam int APB_AW = 12;
   localparam logic [11:0] OFS_PAGE = 12'h000;
   localparam logic [11:0] OFS_SLICE_LOW = 12'h004;
   localparam logic [11:0] OFS_SLICE_HIGH = 12'h008;
   localparam logic [11:0] OFS_BANK = 12'h00c;
   localparam logic [11:0] OFS_OPTION = 12'h010;
   localparam logic [11:0] OFS_STATUS = 12'h014;

   // ********************************************************************
   // Types
   // ********************************************************************
   typedef enum logic [1:0] {am_working, am_register, am_indirect, am_indexed} addr_mode_e;
   typedef enum logic [1:0] {st_idle, st_second, st_last} fsm_e;

   typedef struct packed {
      logic valid;
      addr_mode_e mode;
      logic [7:0] addr;
      logic write;
      logic pair;
      logic [15:0] wdata;
   } core_req_s;

   typedef struct packed {
      logic done;
      logic fault;
      logic [15:0] rdata;
   } core_rsp_s;

   typedef struct packed {
      logic fault;
      logic set1;
      logic [7:0] log;
      logic [11:0] idx;
   } resolve_s;

   typedef struct packed {
      logic vector_hit;
      logic option_hit;
      logic store_en;
      logic [15:0] addr;
   } pm_rsp_s;

endpackage

// [verilog/byte_store.sv]
// Byte-wide register storage with a registered read port
`timescale 1ns/100ps
`default_nettype none

module byte_store #(
   parameter int AW = 12,
   parameter int DW = 8
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Access port
   input wire logic en,
   input wire logic we,
   input wire logic [AW-1:0] addr,
   input wire logic [DW-1:0] wdata,
   output logic [DW-1:0] rdata
);

   logic [DW-1:0] mem [0:(1<<AW)-1];

   // Array carries no reset; contents are undefined until written
   always_ff @(posedge pclk) begin
      if (en && we) begin
         mem[addr] <= wdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata <= '0;
      end else if (en && !we) begin
         rdata <= mem[addr];
      end
   end

endmodule

`default_nettype wire

// [verilog/register_file_address_map.sv]
// Register-file and program-memory address decoder with APB control registers
// Notes on behaviour
// (RULE_01) 16-bit program address, 8-bit register bus
// (RULE_02) Lowest 256 program bytes are vector area
// (RULE_03) Program bytes 3CH-3FH hold start-up options
// (RULE_04) Fetch starts at 0100H after reset
// (RULE_05) Only 3EH and 3FH set start options
// (RULE_06) Program writes never change active options
// (RULE_07) Upper 64 register bytes split set1/set2
// (RULE_08) E0H-FFH banked; reset picks bank 0
// (RULE_09) Page pointer source/destination nibbles reset zero
// (RULE_10) Page pointer expands to six pages
// (RULE_11) Set1 C0H-FFH via register mode, any page; here register mode faults at C0H-CFH
// (RULE_12) Indirect/indexed C0H-FFH go to set2, pages 0-3
// (RULE_13) Set1 holds D0H-DFH system and common area
// (RULE_14) Common area only by working addressing
// (RULE_15) Prime 00H-BFH follows page pointer, all modes
// (RULE_16) Two slice pointers form movable 16-byte block
// (RULE_17) Slice shares five high address bits
// (RULE_18) Reset points block at C0H-CFH
// (RULE_19) Slice pointers at D6H/D7H reset C0H/C8H
// (RULE_20) Working address: pointer high five, three low
// (RULE_21) Pairs start even, high byte even register
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module register_file_address_map #(
   parameter int PM_AW = regmap_pkg::PM_AW,
   parameter int RB_W = regmap_pkg::RB_W,
   parameter int PHYS_AW = regmap_pkg::PHYS_AW
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [regmap_pkg::APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Core register-bus request and answer
   input wire regmap_pkg::core_req_s core_req,
   output regmap_pkg::core_rsp_s core_rsp,
   output logic core_ready,
   // Core bank-select instructions
   input wire logic select_bank_zero_insn,
   input wire logic select_bank_one_insn,
   // Core program-memory access
   input wire logic pm_valid,
   input wire logic pm_write,
   input wire logic [PM_AW-1:0] pm_addr,
   output regmap_pkg::pm_rsp_s pm_rsp,
   output logic [PM_AW-1:0] reset_fetch_addr,
   // External programmer option writes
   input wire logic prog_we,
   input wire logic [PM_AW-1:0] prog_addr,
   input wire logic [RB_W-1:0] prog_data,
   output logic [15:0] option_active
);

   // ********************************************************************
   // State
   // ********************************************************************
   typedef struct packed {
      regmap_pkg::fsm_e st;
      logic [7:0] page_ptr;
      logic [7:0] slice_low;
      logic [7:0] slice_high;
      logic bank;
      logic [15:0] opt;
      regmap_pkg::core_req_s cur;
      logic spec;
      logic [7:0] spec_val;
      logic [7:0] hi_byte;
      regmap_pkg::core_rsp_s rsp;
      logic ready;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      regmap_pkg::pm_rsp_s pm;
      logic [15:0] fetch;
   } state_s;

   state_s r;
   state_s n;

   logic mem_en;
   logic mem_we;
   logic [PHYS_AW-1:0] mem_addr;
   logic [7:0] mem_wdata;
   logic [7:0] mem_rdata;

   logic iss_en;
   logic iss_we;
   logic [7:0] iss_wdata;
   regmap_pkg::resolve_s iss;
   regmap_pkg::resolve_s res;
   logic [7:0] got;

   // ********************************************************************
   // Operand address resolution
   // ********************************************************************
   function automatic regmap_pkg::resolve_s resolve(
      input regmap_pkg::addr_mode_e mode,
      input logic [7:0] a,
      input logic [3:0] page,
      input logic [7:0] lo,
      input logic [7:0] hi,
      input logic bank
   );
      regmap_pkg::resolve_s v;
      logic [7:0] full;
      v = '0;
      full = a;
      if (mode == regmap_pkg::am_working) begin
         // High bit picks the pointer, slice base keeps five bits
         full = a[3] ? {hi[7:3], a[2:0]} : {lo[7:3], a[2:0]}; // see RULE_20 see RULE_17
      end
      v.log = full;
      if (full < regmap_pkg::SET1_BASE) begin
         v.fault = (page >= regmap_pkg::PAGE_COUNT); // see RULE_10
         v.idx = {1'b0, page[2:0], full}; // see RULE_15
      end else if (mode == regmap_pkg::am_indirect || mode == regmap_pkg::am_indexed) begin
         v.fault = (page >= regmap_pkg::SET2_PAGES); // see RULE_12
         v.idx = {1'b0, page[2:0], full}; // see RULE_07
      end else begin
         // Working mode lands here too, so the block can never reach set2
         v.set1 = 1'b1; // see RULE_11 see RULE_16
         v.fault = (mode == regmap_pkg::am_register) && (full <= regmap_pkg::COMMON_END); // see RULE_14
         v.idx = {1'b1, 2'b00, bank && (full >= regmap_pkg::BANKED_BASE), full}; // see RULE_08
      end
      return v;
   endfunction

   // ********************************************************************
   // Next-state logic
   // ********************************************************************
   always_comb begin
      n = r;
      n.rsp.done = 1'b0;
      n.rsp.fault = 1'b0;
      n.pready = 1'b0;
      iss_en = 1'b0;
      iss_we = 1'b0;
      iss_wdata = 8'h00;
      iss = '0;
      res = '0;
      got = r.spec ? r.spec_val : mem_rdata;
      mem_en = 1'b0;
      mem_we = 1'b0;
      mem_addr = '0;
      mem_wdata = 8'h00;

      // APB setup phase prepares the answer; access phase then completes at once
      if (psel && !penable) begin
         n.pready = 1'b1;
         n.pslverr = 1'b0;
         n.prdata = 32'h0000_0000;
         case (paddr)
            regmap_pkg::OFS_PAGE: begin
               n.prdata = {24'h00_0000, r.page_ptr};
            end
            regmap_pkg::OFS_SLICE_LOW: begin
               n.prdata = {24'h00_0000, r.slice_low};
            end
            regmap_pkg::OFS_SLICE_HIGH: begin
               n.prdata = {24'h00_0000, r.slice_high};
            end
            regmap_pkg::OFS_BANK: begin
               n.prdata = {31'h0000_0000, r.bank};
            end
            regmap_pkg::OFS_OPTION: begin
               n.prdata = {16'h0000, r.opt};
            end
            regmap_pkg::OFS_STATUS: begin
               n.prdata = {30'h0000_0000, r.st != regmap_pkg::st_idle, r.bank};
            end
            default: begin
               n.pslverr = 1'b1;
            end
         endcase
      end
      if (psel && penable && r.pready && pwrite) begin
         case (paddr)
            regmap_pkg::OFS_PAGE: begin
               n.page_ptr = pwdata[7:0];
            end
            regmap_pkg::OFS_SLICE_LOW: begin
               n.slice_low = pwdata[7:0];
            end
            regmap_pkg::OFS_SLICE_HIGH: begin
               n.slice_high = pwdata[7:0];
            end
            regmap_pkg::OFS_BANK: begin
               n.bank = pwdata[0];
            end
            default: begin
            end
         endcase
      end

      // Bank instructions outrank a software write in the same cycle
      if (select_bank_zero_insn) begin
         n.bank = 1'b0; // see RULE_08
      end else if (select_bank_one_insn) begin
         n.bank = 1'b1; // see RULE_08
      end

      // Core register-bus sequencer
      case (r.st)
         regmap_pkg::st_idle: begin
            if (core_req.valid) begin
               res = resolve(core_req.mode, core_req.addr,
                  core_req.write ? r.page_ptr[7:4] : r.page_ptr[3:0], // see RULE_09
                  r.slice_low, r.slice_high, r.bank);
               if (res.fault || (core_req.pair && core_req.addr[0])) begin
                  // Odd pair base is refused without touching storage
                  n.rsp.done = 1'b1; // see RULE_21
                  n.rsp.fault = 1'b1;
                  n.rsp.rdata = 16'h0000;
               end else begin
                  n.cur = core_req;
                  iss_en = 1'b1;
                  iss_we = core_req.write;
                  iss = res;
                  // Even register takes the high byte
                  iss_wdata = core_req.pair ? core_req.wdata[15:8] : core_req.wdata[7:0]; // see RULE_21
                  n.st = core_req.pair ? regmap_pkg::st_second : regmap_pkg::st_last;
               end
            end
         end
         regmap_pkg::st_second: begin
            n.hi_byte = got;
            res = resolve(r.cur.mode, r.cur.addr | 8'h01,
               r.cur.write ? r.page_ptr[7:4] : r.page_ptr[3:0],
               r.slice_low, r.slice_high, r.bank);
            iss_en = 1'b1;
            iss_we = r.cur.write;
            iss = res;
            iss_wdata = r.cur.wdata[7:0]; // see RULE_21
            n.st = regmap_pkg::st_last;
         end
         regmap_pkg::st_last: begin
            n.rsp.done = 1'b1;
            n.rsp.rdata = r.cur.pair ? {r.hi_byte, got} : {8'h00, got};
            n.st = regmap_pkg::st_idle;
         end
         default: begin
            n.st = regmap_pkg::st_idle;
         end
      endcase

      // One byte issue shared by both halves of a pair
      if (iss_en) begin
         mem_en = 1'b1;
         mem_we = iss_we;
         mem_addr = iss.idx;
         mem_wdata = iss_wdata;
         n.spec = 1'b0;
         n.spec_val = 8'h00;
         if (iss.set1) begin
            case (iss.log)
               regmap_pkg::SLICE_LOW_ADDR: begin
                  n.spec = 1'b1; // see RULE_19 see RULE_13
                  n.spec_val = r.slice_low;
                  if (iss_we) begin
                     n.slice_low = iss_wdata;
                  end
               end
               regmap_pkg::SLICE_HIGH_ADDR: begin
                  n.spec = 1'b1; // see RULE_19
                  n.spec_val = r.slice_high;
                  if (iss_we) begin
                     n.slice_high = iss_wdata;
                  end
               end
               regmap_pkg::PAGE_PTR_ADDR: begin
                  n.spec = 1'b1; // see RULE_09
                  n.spec_val = r.page_ptr;
                  if (iss_we) begin
                     n.page_ptr = iss_wdata;
                  end
               end
               default: begin
               end
            endcase
         end
      end
      n.ready = (n.st == regmap_pkg::st_idle);

      // Program-memory decode, one cycle behind the core
      n.pm.addr = pm_addr; // see RULE_01
      n.pm.vector_hit = pm_valid && (pm_addr <= regmap_pkg::VECTOR_END); // see RULE_02
      n.pm.option_hit = pm_valid && (pm_addr >= regmap_pkg::OPT_FIRST)
         && (pm_addr <= regmap_pkg::OPT_LAST); // see RULE_03
      // Storage may change; the latched options below do not follow it
      n.pm.store_en = pm_valid && pm_write; // see RULE_06
      n.fetch = regmap_pkg::RESET_PC; // see RULE_04

      // Only the programmer port loads the active start-up options
      if (prog_we && prog_addr == regmap_pkg::OPT_HI_ADDR) begin
         n.opt[15:8] = prog_data; // see RULE_05 see RULE_06
      end else if (prog_we && prog_addr == regmap_pkg::OPT_LO_ADDR) begin
         n.opt[7:0] = prog_data; // see RULE_05
      end
   end

   // ********************************************************************
   // State register
   // ********************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
         r.st <= regmap_pkg::st_idle;
         r.page_ptr <= regmap_pkg::PAGE_RST; // see RULE_09
         r.slice_low <= regmap_pkg::SLICE_LOW_RST; // see RULE_18 see RULE_19
         r.slice_high <= regmap_pkg::SLICE_HIGH_RST; // see RULE_18 see RULE_19
         r.bank <= regmap_pkg::BANK_RST; // see RULE_08
         r.opt <= regmap_pkg::OPT_RST;
         r.ready <= 1'b1;
         r.fetch <= regmap_pkg::RESET_PC; // see RULE_04
      end else begin
         r <= n;
      end
   end

   // ********************************************************************
   // Storage and outputs
   // ********************************************************************
   byte_store #(
      .AW(PHYS_AW),
      .DW(RB_W)
   ) u_store (
      .pclk(pclk),
      .presetn(presetn),
      .en(mem_en),
      .we(mem_we),
      .addr(mem_addr),
      .wdata(mem_wdata),
      .rdata(mem_rdata)
   );

   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign core_rsp = r.rsp;
   assign core_ready = r.ready;
   assign pm_rsp = r.pm;
   assign reset_fetch_addr = r.fetch;
   assign option_active = r.opt;

endmodule

`default_nettype wire

// [tb/regmap_asserts.sv]
// Concurrent checks on the address decoder's ports
`timescale 1ns/100ps
`default_nettype none

module regmap_asserts #(
   parameter int PM_AW = 16,
   parameter int RB_W = 8
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   // Core register bus
   input wire regmap_pkg::core_req_s core_req,
   input wire regmap_pkg::core_rsp_s core_rsp,
   input wire logic core_ready,
   // Program memory and options
   input wire logic pm_valid,
   input wire logic [PM_AW-1:0] pm_addr,
   input wire regmap_pkg::pm_rsp_s pm_rsp,
   input wire logic [PM_AW-1:0] reset_fetch_addr,
   input wire logic prog_we,
   input wire logic [PM_AW-1:0] prog_addr,
   input wire logic [RB_W-1:0] prog_data,
   input wire logic [15:0] option_active
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   AST_FETCH_ENTRY: assert property (reset_fetch_addr == 16'h0100)
      else $error("fetch entry address wrong");
   AST_VECTOR_AREA: assert property (pm_valid |=>
      pm_rsp.vector_hit == ($past(pm_addr) <= 16'h00ff)) else $error("vector decode wrong");
   AST_OPTION_CELL: assert property (pm_valid |=> pm_rsp.option_hit ==
      ($past(pm_addr) >= 16'h003c && $past(pm_addr) <= 16'h003f)) else $error("option decode");
   AST_OPT_ONLY_PROG: assert property (!(prog_we && (prog_addr == 16'h003e ||
      prog_addr == 16'h003f)) |=> $stable(option_active)) else $error("option changed");
   AST_OPT_HI_LOAD: assert property (prog_we && prog_addr == 16'h003e |=>
      option_active[15:8] == $past(prog_data)) else $error("option high byte not loaded");
   AST_COMMON_FAULT: assert property (core_req.valid && core_ready &&
      core_req.mode == regmap_pkg::am_register && core_req.addr[7:4] == 4'hc
      |=> core_rsp.done && core_rsp.fault) else $error("common area reached by register mode");
   AST_PAIR_ODD: assert property (core_req.valid && core_ready && core_req.pair &&
      core_req.addr[0] |=> core_rsp.done && core_rsp.fault) else $error("odd pair accepted");
   AST_PAIR_SPAN: assert property (core_req.valid && core_ready && core_req.pair &&
      !core_req.addr[0] && core_req.mode == regmap_pkg::am_working
      |=> !core_ready [*2] ##1 (core_rsp.done && !core_rsp.fault && core_ready))
      else $error("pair transfer timing wrong");
   AST_SET1_ANY_PAGE: assert property (core_req.valid && core_ready &&
      core_req.mode == regmap_pkg::am_register && core_req.addr >= 8'he0 && !core_req.pair
      |=> !core_rsp.done ##1 (core_rsp.done && !core_rsp.fault)) else $error("set1 access failed");
   AST_APB_ANSWER: assert property (psel && !penable |=> pready)
      else $error("no APB answer");
endmodule

bind register_file_address_map regmap_asserts #(.PM_AW(PM_AW), .RB_W(RB_W)) i_regmap_asserts (.*);
`default_nettype wire

// [tb/core_model.sv]
// Behavioural CPU core issuing register-bus transfers
`timescale 1ns/100ps
`default_nettype none

module core_model (
   // Clock
   input wire logic pclk,
   // Register bus
   output var regmap_pkg::core_req_s core_req,
   input wire regmap_pkg::core_rsp_s core_rsp,
   input wire logic core_ready
);
   initial begin
      core_req = '0;
   end

   // Bounded waits only; a stuck sequencer is reported, not hung on
   task automatic access(input regmap_pkg::addr_mode_e m, input logic [7:0] a, input logic w,
      input logic p, input logic [15:0] d, output logic [15:0] rd, output logic flt,
      output logic tout);
      int n;
      n = 0;
      @(posedge pclk);
      while (core_ready !== 1'b1 && n < 16) begin
         @(posedge pclk);
         n++;
      end
      core_req <= '{valid: 1'b1, mode: m, addr: a, write: w, pair: p, wdata: d};
      @(posedge pclk);
      // Released qualifiers other than mode show the inverse
      core_req <= '{valid: 1'b0, mode: m, addr: ~a, write: ~w, pair: ~p, wdata: ~d};
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (core_rsp.done !== 1'b1 && n < 16);
      rd = core_rsp.rdata;
      flt = core_rsp.fault;
      tout = (core_rsp.done !== 1'b1);
   endtask
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the register-file address decoder
`timescale 1ns/100ps
`default_nettype none

module testbench;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [regmap_pkg::APB_AW-1:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata;
   logic pready, pslverr, core_ready, pm_valid = 1'b0, pm_write = 1'b0, prog_we = 1'b0;
   logic select_bank_zero_insn = 1'b0, select_bank_one_insn = 1'b0;
   logic [15:0] pm_addr = '0, prog_addr = '0, reset_fetch_addr, option_active;
   logic [7:0] prog_data = '0;
   regmap_pkg::core_req_s core_req;
   regmap_pkg::core_rsp_s core_rsp;
   regmap_pkg::pm_rsp_s pm_rsp;
   int fails = 0, n_tests = 0;
   localparam regmap_pkg::addr_mode_e MREG = regmap_pkg::am_register;

   register_file_address_map i_register_file_address_map (.*);
   core_model i_core_model (.*);

   initial begin
      forever #25 pclk = ~pclk;
   end

   // ********************************************************************
   // Shared tasks
   // ********************************************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("checks=%0d mismatches=%0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic do_reset();
      presetn <= 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic er);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         fails++;
         give_verdict();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic aw(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic er;
      apb(1'b1, a, d, rd, er);
   endtask

   task automatic ar(input logic [11:0] a, input logic [31:0] ex);
      logic [31:0] rd;
      logic er;
      apb(1'b0, a, 32'h0, rd, er);
      chk(rd, ex);
      chk(er, 1'b0);
   endtask

   task automatic core(input regmap_pkg::addr_mode_e m, input logic [7:0] a, input logic w,
      input logic p, input logic [15:0] d, input logic ef);
      logic [15:0] rd;
      logic flt, tout;
      i_core_model.access(m, a, w, p, d, rd, flt, tout);
      if (tout) begin
         fails++;
         give_verdict();
      end
      chk(flt, ef);
      if (!w && !ef) chk(rd, d);
   endtask

   task automatic prog(input logic [15:0] a, input logic [7:0] d);
      @(posedge pclk);
      prog_we <= 1'b1;
      prog_addr <= a;
      prog_data <= d;
      @(posedge pclk);
      prog_we <= 1'b0;
      prog_addr <= ~a;
      prog_data <= ~d;
   endtask

   task automatic pm(input logic [15:0] a, input logic w);
      @(posedge pclk);
      pm_valid <= 1'b1;
      pm_write <= w;
      pm_addr <= a;
      @(posedge pclk);
      pm_valid <= 1'b0;
      pm_write <= 1'b0;
      pm_addr <= ~a;
      @(negedge pclk);
      chk({pm_rsp.vector_hit, pm_rsp.option_hit}, {a <= 16'h00ff, a >= 16'h003c && a <= 16'h003f});
      chk(pm_rsp.store_en, w);
   endtask

   task automatic bank_pulse(input logic z, input logic o);
      @(posedge pclk);
      select_bank_zero_insn <= z;
      select_bank_one_insn <= o;
      @(posedge pclk);
      select_bank_zero_insn <= 1'b0;
      select_bank_one_insn <= 1'b0;
   endtask

   // ********************************************************************
   // Scenarios
   // ********************************************************************
   task automatic t_reset();
      logic [31:0] rd;
      logic er;
      chk(reset_fetch_addr, 16'h0100);
      ar(regmap_pkg::OFS_PAGE, 32'h00);
      ar(regmap_pkg::OFS_SLICE_LOW, 32'hc0);
      ar(regmap_pkg::OFS_SLICE_HIGH, 32'hc8);
      ar(regmap_pkg::OFS_STATUS, 32'h0);
      ar(regmap_pkg::OFS_OPTION, 32'h0);
      apb(1'b0, 12'h020, 32'h0, rd, er);
      chk(er, 1'b1);
   endtask

   task automatic t_program();
      logic [15:0] tbl [9] = '{16'h0000, 16'h003b, 16'h003c, 16'h003d, 16'h003f, 16'h0040,
         16'h00ff, 16'h0100, 16'hffff};
      foreach (tbl[i]) pm(tbl[i], 1'b0);
      pm(16'h003e, 1'b1);
      prog(16'h003c, 8'haa);
      prog(16'h003d, 8'hbb);
      chk(option_active, 16'h0000);
      prog(16'h003e, 8'h12);
      prog(16'h003f, 8'h34);
      pm(16'h003f, 1'b1);
      chk(option_active, 16'h1234);
      ar(regmap_pkg::OFS_OPTION, 32'h1234);
   endtask

   task automatic t_working();
      core(regmap_pkg::am_working, 8'h00, 1'b1, 1'b1, 16'ha55a, 1'b0);
      core(regmap_pkg::am_working, 8'h00, 1'b0, 1'b1, 16'ha55a, 1'b0);
      core(MREG, 8'hc1, 1'b0, 1'b0, 16'h0, 1'b1);
      core(MREG, 8'h21, 1'b1, 1'b1, 16'h1, 1'b1);
      aw(regmap_pkg::OFS_SLICE_LOW, 32'h85);
      core(regmap_pkg::am_working, 8'h02, 1'b1, 1'b0, 16'h0033, 1'b0);
      core(MREG, 8'h82, 1'b0, 1'b0, 16'h0033, 1'b0);
      core(MREG, 8'hd7, 1'b1, 1'b0, 16'h0048, 1'b0);
      ar(regmap_pkg::OFS_SLICE_HIGH, 32'h48);
      core(regmap_pkg::am_working, 8'h0b, 1'b1, 1'b0, 16'h0077, 1'b0);
      core(MREG, 8'h4b, 1'b0, 1'b0, 16'h0077, 1'b0);
      core(MREG, 8'h20, 1'b1, 1'b1, 16'h1234, 1'b0);
      core(MREG, 8'h20, 1'b0, 1'b0, 16'h0012, 1'b0);
      core(MREG, 8'h21, 1'b0, 1'b0, 16'h0034, 1'b0);
   endtask

   task automatic t_pages();
      aw(regmap_pkg::OFS_PAGE, 32'h55);
      core(MREG, 8'h10, 1'b1, 1'b0, 16'h0011, 1'b0);
      aw(regmap_pkg::OFS_PAGE, 32'h00);
      core(MREG, 8'h10, 1'b1, 1'b0, 16'h0022, 1'b0);
      aw(regmap_pkg::OFS_PAGE, 32'h05);
      core(MREG, 8'h10, 1'b0, 1'b0, 16'h0011, 1'b0);
      aw(regmap_pkg::OFS_PAGE, 32'h66);
      core(regmap_pkg::am_indexed, 8'h10, 1'b0, 1'b0, 16'h0, 1'b1);
      aw(regmap_pkg::OFS_PAGE, 32'h33);
      core(regmap_pkg::am_indirect, 8'he0, 1'b1, 1'b0, 16'h0044, 1'b0);
      core(MREG, 8'he0, 1'b1, 1'b0, 16'h0066, 1'b0);
      core(regmap_pkg::am_indexed, 8'he0, 1'b0, 1'b0, 16'h0044, 1'b0);
      aw(regmap_pkg::OFS_PAGE, 32'h44);
      core(regmap_pkg::am_indirect, 8'he0, 1'b0, 1'b0, 16'h0, 1'b1);
      core(MREG, 8'he0, 1'b0, 1'b0, 16'h0066, 1'b0);
   endtask

   task automatic t_bank();
      core(MREG, 8'he5, 1'b1, 1'b0, 16'h0010, 1'b0);
      core(MREG, 8'hd0, 1'b1, 1'b0, 16'h005a, 1'b0);
      bank_pulse(1'b0, 1'b1);
      ar(regmap_pkg::OFS_STATUS, 32'h1);
      core(MREG, 8'he5, 1'b1, 1'b0, 16'h0020, 1'b0);
      core(MREG, 8'hd0, 1'b0, 1'b0, 16'h005a, 1'b0);
      bank_pulse(1'b1, 1'b1);
      core(MREG, 8'he5, 1'b0, 1'b0, 16'h0010, 1'b0);
      bank_pulse(1'b0, 1'b1);
      core(MREG, 8'he5, 1'b0, 1'b0, 16'h0020, 1'b0);
      // Mid-run reset must restore bank and the high slice pointer
      do_reset();
      ar(regmap_pkg::OFS_STATUS, 32'h0);
      ar(regmap_pkg::OFS_SLICE_HIGH, 32'hc8);
   endtask

   initial begin
      do_reset();
      t_reset();
      t_program();
      t_working();
      t_pages();
      t_bank();
      give_verdict();
   end
endmodule
`default_nettype wire
